// >>> inc/acrm_consts.vh
// Constants for the accelerometer register bank: offsets, reset values,
// the identity code and field positions.
// Assumes inclusion by bare name from the design files.
`ifndef ACRM_CONSTS_VH
`define ACRM_CONSTS_VH

// Register offsets.
`define ACRM_A_FLAGS       8'h00
`define ACRM_A_X_HI        8'h01
`define ACRM_A_X_LO        8'h02
`define ACRM_A_Y_HI        8'h03
`define ACRM_A_Y_LO        8'h04
`define ACRM_A_Z_HI        8'h05
`define ACRM_A_Z_LO        8'h06
`define ACRM_A_RSV0        8'h07
`define ACRM_A_RSV1        8'h08
`define ACRM_A_BUF_SETUP   8'h09
`define ACRM_A_BUF_TRIG    8'h0a
`define ACRM_A_SYS_STATE   8'h0b
`define ACRM_A_INT_CAUSE   8'h0c
`define ACRM_A_IDENTITY    8'h0d
`define ACRM_A_RANGE_FILT  8'h0e
`define ACRM_A_HP_CUTOFF   8'h0f
`define ACRM_A_ORIENT_ST   8'h10
`define ACRM_A_ORIENT_CFG  8'h11
`define ACRM_A_ORIENT_DBC  8'h12
`define ACRM_A_BF_TRIP     8'h13
`define ACRM_A_PL_TRIP     8'h14
`define ACRM_A_FFMT_CFG    8'h15
`define ACRM_FREEFALL_MOTION_SOURCE    8'h16
`define ACRM_A_FFMT_THS    8'h17
`define ACRM_A_FFMT_DBC    8'h18
`define ACRM_A_LAST        8'h18
`define ACRM_A_NEXT_BLOCK  8'h19

// Reset values of the writable registers.
`define ACRM_RST_ZERO      8'h00
`define ACRM_RST_ORIENT    8'h80
`define ACRM_RST_PL_TRIP   8'h1a

// Identity code; the value is arbitrary.
`define ACRM_IDENTITY_VAL  8'h5c

// Field positions: buffer mode in the setup register, low-byte pad bits.
`define ACRM_FMODE_HI      7
`define ACRM_FMODE_LO      6
`define ACRM_LOW_PAD       2'b00

`endif

// >>> verilog/acrm_regbank.v
// Register bank of a 3-axis accelerometer, addresses 00h to 18h, with
// the auto-increment pointer that depends on buffer mode and fast read.
// Assumes a serial front end that delivers address, write and read
// strobes synchronous to ref_clk, and detection logic that supplies
// the sample and status values on plain inputs.
// The bank holds no sample storage of its own: while the buffer is
// active the buffer logic presents its head entry, and fifo_pop asks
// it to move on after each X high read.
//
// Behaviour
// - Buffer off and fast read on: pointer goes X high to Y high (03h) to Z high (05h).
// - Buffer on and fast read on: pointer returns to X high after X high is read.
// - Each axis high byte shows the 8 top bits of its 14-bit sample in bits 7..0.
// - Each axis low byte shows the 6 low sample bits in bits 7..2, bits 1..0 zero.
// - The X high byte address is the read port for buffered XYZ samples.
// - Address 00h is read-only, shows data-ready flags or buffer status, holds no reset value of its own.
// - Buffer off and normal read: pointer steps through every high and low byte.
// - Buffer on and normal read: X high is followed by X high again.
`timescale 1ns/100ps
`default_nettype none
`include "acrm_consts.vh"

module acrm_regbank (
  // Clock and reset.
  input  wire        ref_clk,
  input  wire        rstn,
  // Host access strobes from the serial front end.
  input  wire        addr_load,
  input  wire [7:0]  addr_in,
  input  wire        wr_stb,
  input  wire [7:0]  wr_data,
  input  wire        rd_stb,
  output reg  [7:0]  rd_data,
  output reg  [7:0]  reg_ptr,
  // Fast-read bit of the primary control register.
  input  wire        fast_read,
  // Live values from the sensing and detection logic.
  input  wire [13:0] x_sample,
  input  wire [13:0] y_sample,
  input  wire [13:0] z_sample,
  input  wire [13:0] fifo_x,
  input  wire [13:0] fifo_y,
  input  wire [13:0] fifo_z,
  input  wire [7:0]  data_ready_flags,
  input  wire [7:0]  fifo_status,
  input  wire [7:0]  sys_state_in,
  input  wire [7:0]  int_cause_in,
  input  wire [7:0]  orient_state_in,
  input  wire [7:0]  ffmt_source_in,
  // Pop request to the sample buffer, one cycle per X high read while the buffer is active.
  output reg         fifo_pop,
  // Configuration outputs to the detection and buffer logic.
  // Each is the register itself, so downstream logic sees a write at once.
  output reg  [7:0]  buffer_setup_r,
  output reg  [7:0]  buffer_trigger_config_r,
  output reg  [7:0]  range_and_filter_select_r,
  output reg  [7:0]  highpass_cutoff_select_r,
  output reg  [7:0]  orientation_config_r,
  output reg  [7:0]  orientation_debounce_r,
  output reg  [7:0]  backfront_trip_angle_r,
  output reg  [7:0]  portrait_landscape_trip_r,
  output reg  [7:0]  freefall_motion_config_r,
  output reg  [7:0]  freefall_motion_threshold_r,
  output reg  [7:0]  freefall_motion_debounce_r
);

  // ---------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------

  // The buffer counts as active whenever its mode field is non-zero.
  // All non-zero codes share one pointer behaviour here; how the buffer
  // fills or stops is the buffer logic's business, not this bank's.
  wire       fifo_on;
  wire [1:0] fmode;
  assign fmode   = buffer_setup_r[`ACRM_FMODE_HI:`ACRM_FMODE_LO];
  assign fifo_on = (fmode != 2'b00);

  // ---------------------------------------------------------------------
  // Axis formatting
  // ---------------------------------------------------------------------

  // The three axes are packed with X in the low slice. The source switch
  // makes address 01h the buffer read port while the buffer is active;
  // the live sample is hidden then, which is the price of sharing it.
  wire [41:0] axis_live;
  wire [41:0] axis_buf;
  wire [23:0] axis_hi;
  wire [23:0] axis_lo;
  assign axis_live = {z_sample, y_sample, x_sample};
  assign axis_buf  = {fifo_z, fifo_y, fifo_x};

  // One slice per axis: the high byte takes sample bits 13..6, the low
  // byte takes bits 5..0 above two zero pad bits.
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      wire [13:0] sel;
      assign sel = fifo_on ? axis_buf[ax*14 +: 14] : axis_live[ax*14 +: 14];
      assign axis_hi[ax*8 +: 8] = sel[13:6];
      assign axis_lo[ax*8 +: 8] = {sel[5:0], `ACRM_LOW_PAD};
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------

  // Reserved and unmapped addresses read as zero.
  // The mux looks at the pointer before it steps, so rd_data belongs to
  // the address the host asked for, not to the next one.
  reg [7:0] rd_nxt;
  always @* begin
    rd_nxt = 8'h00;
    if (reg_ptr == `ACRM_A_FLAGS) begin
      rd_nxt = fifo_on ? fifo_status : data_ready_flags;
    end else if (reg_ptr == `ACRM_A_X_HI) begin
      rd_nxt = axis_hi[7:0];
    end else if (reg_ptr == `ACRM_A_X_LO) begin
      rd_nxt = axis_lo[7:0];
    end else if (reg_ptr == `ACRM_A_Y_HI) begin
      rd_nxt = axis_hi[15:8];
    end else if (reg_ptr == `ACRM_A_Y_LO) begin
      rd_nxt = axis_lo[15:8];
    end else if (reg_ptr == `ACRM_A_Z_HI) begin
      rd_nxt = axis_hi[23:16];
    end else if (reg_ptr == `ACRM_A_Z_LO) begin
      rd_nxt = axis_lo[23:16];
    end else if (reg_ptr == `ACRM_A_BUF_SETUP) begin
      rd_nxt = buffer_setup_r;
    end else if (reg_ptr == `ACRM_A_BUF_TRIG) begin
      rd_nxt = buffer_trigger_config_r;
    end else if (reg_ptr == `ACRM_A_SYS_STATE) begin
      rd_nxt = sys_state_in;
    end else if (reg_ptr == `ACRM_A_INT_CAUSE) begin
      rd_nxt = int_cause_in;
    end else if (reg_ptr == `ACRM_A_IDENTITY) begin
      rd_nxt = `ACRM_IDENTITY_VAL;
    end else if (reg_ptr == `ACRM_A_RANGE_FILT) begin
      rd_nxt = range_and_filter_select_r;
    end else if (reg_ptr == `ACRM_A_HP_CUTOFF) begin
      rd_nxt = highpass_cutoff_select_r;
    end else if (reg_ptr == `ACRM_A_ORIENT_ST) begin
      rd_nxt = orient_state_in;
    end else if (reg_ptr == `ACRM_A_ORIENT_CFG) begin
      rd_nxt = orientation_config_r;
    end else if (reg_ptr == `ACRM_A_ORIENT_DBC) begin
      rd_nxt = orientation_debounce_r;
    end else if (reg_ptr == `ACRM_A_BF_TRIP) begin
      rd_nxt = backfront_trip_angle_r;
    end else if (reg_ptr == `ACRM_A_PL_TRIP) begin
      rd_nxt = portrait_landscape_trip_r;
    end else if (reg_ptr == `ACRM_A_FFMT_CFG) begin
      rd_nxt = freefall_motion_config_r;
    end else if (reg_ptr == `ACRM_FREEFALL_MOTION_SOURCE) begin
      rd_nxt = ffmt_source_in;
    end else if (reg_ptr == `ACRM_A_FFMT_THS) begin
      rd_nxt = freefall_motion_threshold_r;
    end else if (reg_ptr == `ACRM_A_FFMT_DBC) begin
      rd_nxt = freefall_motion_debounce_r;
    end
  end

  // ---------------------------------------------------------------------
  // Auto-increment table
  // ---------------------------------------------------------------------

  // Output bytes follow one of four sequences; every other register
  // simply steps by one. Only the output block differs by mode.
  // A pointer that runs past 18h keeps counting into the next block,
  // which lives outside this bank and reads as zero here.
  reg [7:0] ptr_nxt;
  always @* begin
    ptr_nxt = reg_ptr + 8'h01;
    if (reg_ptr == `ACRM_A_FLAGS) begin
      ptr_nxt = `ACRM_A_X_HI;
    end else if (reg_ptr <= `ACRM_A_Z_LO) begin
      case ({fifo_on, fast_read})
        2'b00: begin
          // Every high and low byte in turn, then wrap to flags.
          if (reg_ptr == `ACRM_A_Z_LO) begin
            ptr_nxt = `ACRM_A_FLAGS;
          end
        end
        2'b10: begin
          // X high repeats so bursts keep draining buffer entries.
          if (reg_ptr == `ACRM_A_X_HI) begin
            ptr_nxt = `ACRM_A_X_HI;
          end else if (reg_ptr == `ACRM_A_Z_LO) begin
            ptr_nxt = `ACRM_A_FLAGS;
          end
        end
        2'b01: begin
          // High bytes only, low bytes skipped.
          if (reg_ptr == `ACRM_A_X_HI) begin
            ptr_nxt = `ACRM_A_Y_HI;
          end else if (reg_ptr == `ACRM_A_Y_HI) begin
            ptr_nxt = `ACRM_A_Z_HI;
          end else begin
            // Low bytes and Z high fall back to the status register.
            ptr_nxt = `ACRM_A_FLAGS;
          end
        end
        default: begin
          // Only X high repeats; the rest of the output block ends at 00h.
          if (reg_ptr == `ACRM_A_X_HI) begin
            ptr_nxt = `ACRM_A_X_HI;
          end else begin
            ptr_nxt = `ACRM_A_FLAGS;
          end
        end
      endcase
    end else if (reg_ptr == `ACRM_A_RSV0) begin
      // The reserved pair is stepped through like any other byte.
      ptr_nxt = `ACRM_A_RSV1;
    end
  end

  // ---------------------------------------------------------------------
  // Pointer, read data and pop
  // ---------------------------------------------------------------------

  // A new address overrides any stepping in the same cycle. Reads and
  // writes both advance the pointer once per byte.
  // A read and a write in one cycle still advance only once, since both
  // strobes share the single step below.
  // The pointer restarts at the status register, so a bare read burst
  // after reset begins with the flags.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_ptr  <= `ACRM_A_FLAGS;
      rd_data  <= `ACRM_RST_ZERO;
      fifo_pop <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (addr_load) begin
        reg_ptr <= addr_in;
      end else if (rd_stb || wr_stb) begin
        reg_ptr <= ptr_nxt;
      end
      // A read that meets a pointer load is dropped; the load wins.
      if (rd_stb && !addr_load) begin
        rd_data <= rd_nxt;
        // Pop only on the X high byte, after which the next entry shows.
        fifo_pop <= fifo_on && (reg_ptr == `ACRM_A_X_HI);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------------

  // Writes to read-only and reserved addresses are dropped, so the
  // reserved bytes stay intact even if the host breaks its promise.
  // The decode uses the pointer before it steps, so a write burst fills
  // consecutive registers in address order.
  wire wr_ok;
  assign wr_ok = wr_stb && !addr_load;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // Two registers wake up non-zero; every other one clears.
      buffer_setup_r              <= `ACRM_RST_ZERO;
      buffer_trigger_config_r     <= `ACRM_RST_ZERO;
      range_and_filter_select_r   <= `ACRM_RST_ZERO;
      highpass_cutoff_select_r    <= `ACRM_RST_ZERO;
      orientation_config_r        <= `ACRM_RST_ORIENT;
      orientation_debounce_r      <= `ACRM_RST_ZERO;
      backfront_trip_angle_r      <= `ACRM_RST_ZERO;
      portrait_landscape_trip_r   <= `ACRM_RST_PL_TRIP;
      freefall_motion_config_r    <= `ACRM_RST_ZERO;
      freefall_motion_threshold_r <= `ACRM_RST_ZERO;
      freefall_motion_debounce_r  <= `ACRM_RST_ZERO;
    end else if (wr_ok) begin
      if (reg_ptr == `ACRM_A_BUF_SETUP) begin
        buffer_setup_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_BUF_TRIG) begin
        buffer_trigger_config_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_RANGE_FILT) begin
        range_and_filter_select_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_HP_CUTOFF) begin
        highpass_cutoff_select_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_ORIENT_CFG) begin
        orientation_config_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_ORIENT_DBC) begin
        orientation_debounce_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_BF_TRIP) begin
        backfront_trip_angle_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_PL_TRIP) begin
        portrait_landscape_trip_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_FFMT_CFG) begin
        freefall_motion_config_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_FFMT_THS) begin
        freefall_motion_threshold_r <= wr_data;
      end else if (reg_ptr == `ACRM_A_FFMT_DBC) begin
        freefall_motion_debounce_r <= wr_data;
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/acrm_regbank_properties.sv
// Checker for pointer stepping and read data of the register bank.
// Assumes one clock domain and a bind onto acrm_regbank.
`timescale 1ns/100ps
`default_nettype none
`include "acrm_consts.vh"
module acrm_regbank_chk (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Host strobes and results.
  input wire logic        addr_load,
  input wire logic [7:0]  addr_in,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rd_data,
  input wire logic [7:0]  reg_ptr,
  input wire logic        fifo_pop,
  // Mode and live values.
  input wire logic        fast_read,
  input wire logic [13:0] x_sample,
  input wire logic [7:0]  data_ready_flags,
  input wire logic [7:0]  fifo_status,
  input wire logic [7:0]  buffer_setup_r
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A strobe that meets a pointer load is dropped, so only clean reads count.
  wire       rd_ok  = rd_stb && !addr_load;
  wire       buf_on = buffer_setup_r[7:6] != 2'b00;
  logic [7:0] x_hi_q;
  logic [7:0] flags_q;
  // Inputs as they stood at the taking edge.
  always_ff @(posedge ref_clk) begin
    x_hi_q  <= x_sample[13:6];
    flags_q <= buf_on ? fifo_status : data_ready_flags;
  end
  sequence x_hi_buf_rd;
    rd_ok && buf_on && reg_ptr == `ACRM_A_X_HI;
  endsequence
  chk_ptr_load:
    assert property (addr_load |=> reg_ptr == $past(addr_in)) else $error("load lost");
  chk_fast_skip:
    assert property (rd_ok && fast_read && !buf_on && reg_ptr == 8'h01 |=> reg_ptr == 8'h03)
      else $error("X to Y skip wrong");
  chk_fast_y_z:
    assert property (rd_ok && fast_read && !buf_on && reg_ptr == 8'h03 |=> reg_ptr == 8'h05)
      else $error("Y to Z skip wrong");
  chk_fifo_wrap:
    assert property (x_hi_buf_rd |=> reg_ptr == 8'h01) else $error("no wrap to X high");
  chk_fifo_pop:
    assert property (x_hi_buf_rd |-> ##[1:2] fifo_pop) else $error("no buffer pop");
  chk_x_high:
    assert property (rd_ok && !buf_on && reg_ptr == 8'h01 |=> rd_data == x_hi_q)
      else $error("X high data wrong");
  chk_low_pad:
    assert property (rd_ok && reg_ptr inside {8'h02, 8'h04, 8'h06} |=> rd_data[1:0] == 2'b00)
      else $error("low pad not zero");
  chk_norm_step:
    assert property (rd_ok && !fast_read && !buf_on && reg_ptr <= 8'h05
      |=> reg_ptr == $past(reg_ptr) + 8'h01) else $error("normal step wrong");
  chk_flags_src:
    assert property (rd_ok && reg_ptr == 8'h00 |=> rd_data == flags_q) else $error("flags wrong");
  chk_ro_write:
    assert property (wr_stb && !addr_load && reg_ptr < 8'h09 |=> $stable(buffer_setup_r))
      else $error("read-only write took effect");
endmodule
bind acrm_regbank acrm_regbank_chk u_chk (.ref_clk, .rstn, .addr_load, .addr_in, .wr_stb,
  .rd_stb, .rd_data, .reg_ptr, .fifo_pop, .fast_read, .x_sample, .data_ready_flags,
  .fifo_status, .buffer_setup_r);
`default_nettype wire

// >>> test/acrm_host_model.sv
// Host model that issues pointer loads, writes and reads.
// Assumes the bank takes strobes on the rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module acrm_host_model (
  // Clock.
  input  wire logic       ref_clk,
  // Strobes toward the register bank.
  output var  logic       addr_load,
  output var  logic [7:0] addr_in,
  output var  logic       wr_stb,
  output var  logic [7:0] wr_data,
  output var  logic       rd_stb
);
  // --------
  // Strobing
  // --------
  initial begin
    {addr_load, wr_stb, rd_stb, addr_in, wr_data} = '0;
  end
  // One cycle strobe; data then shows its inverse so stale values never pass.
  task automatic strobe(input logic ld, input logic wr, input logic rd, input logic [7:0] d);
    @(posedge ref_clk);
    {addr_load, wr_stb, rd_stb} <= {ld, wr, rd};
    addr_in <= d;
    wr_data <= d;
    @(posedge ref_clk);
    {addr_load, wr_stb, rd_stb} <= 3'b000;
    addr_in <= ~d;
    wr_data <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> test/acrm_regbank_tb.sv
// Self-checking bench for the register bank, with a reference model.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "acrm_consts.vh"
module acrm_regbank_tb;
  // -----
  // Setup
  // -----
  localparam logic [24:0] RW_MASK = 25'h1bec600;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        fast_read = 1'b0;
  logic        addr_load, wr_stb, rd_stb, fifo_pop;
  logic [7:0]  addr_in, wr_data, rd_data, reg_ptr;
  logic [13:0] smp [0:5];
  logic [7:0]  live [0:5];
  logic [7:0]  cfg [0:10];
  logic [31:0] rng = 32'hb8db;
  int          rw [0:24];
  int          err_count = 0;
  int          n_checks = 0;
  // Free running clock at 250 MHz.
  always #2 ref_clk = ~ref_clk;
  acrm_host_model u_acrm_host_model (.ref_clk(ref_clk), .addr_load(addr_load),
    .addr_in(addr_in), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb));
  acrm_regbank u_acrm_regbank (.ref_clk(ref_clk), .rstn(rstn), .addr_load(addr_load),
    .addr_in(addr_in), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_data(rd_data), .reg_ptr(reg_ptr), .fast_read(fast_read), .x_sample(smp[0]),
    .y_sample(smp[1]), .z_sample(smp[2]), .fifo_x(smp[3]), .fifo_y(smp[4]), .fifo_z(smp[5]),
    .data_ready_flags(live[0]), .fifo_status(live[1]), .sys_state_in(live[2]),
    .int_cause_in(live[3]), .orient_state_in(live[4]), .ffmt_source_in(live[5]),
    .fifo_pop(fifo_pop), .buffer_setup_r(cfg[0]), .buffer_trigger_config_r(cfg[1]),
    .range_and_filter_select_r(cfg[2]), .highpass_cutoff_select_r(cfg[3]),
    .orientation_config_r(cfg[4]), .orientation_debounce_r(cfg[5]),
    .backfront_trip_angle_r(cfg[6]), .portrait_landscape_trip_r(cfg[7]),
    .freefall_motion_config_r(cfg[8]), .freefall_motion_threshold_r(cfg[9]),
    .freefall_motion_debounce_r(cfg[10]));
  // -----
  // Model
  // -----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Next pointer from the four auto-increment sequences of the output block.
  function automatic logic [7:0] nxt(input logic [7:0] a);
    logic b;
    b = rw[9][7:6] != 2'b00;
    if (a > 8'h06 || a == 8'h00) return a + 8'h01;
    if (!fast_read) return (b && a == 8'h01) ? 8'h01 : (a == 8'h06 ? 8'h00 : a + 8'h01);
    if (a == 8'h01) return b ? 8'h01 : 8'h03;
    return (!b && a == 8'h03) ? 8'h05 : 8'h00;
  endfunction
  function automatic logic [7:0] expv(input logic [7:0] a);
    logic [13:0] s;
    logic        b;
    b = rw[9][7:6] != 2'b00;
    s = smp[(a > 8'h06 || a == 8'h00) ? 0 : (a - 8'h01) / 2 + (b ? 3 : 0)];
    case (a)
      8'h00: return b ? live[1] : live[0];
      8'h01, 8'h03, 8'h05: return s[13:6];
      8'h02, 8'h04, 8'h06: return {s[5:0], 2'b00};
      8'h0b: return live[2];
      8'h0c: return live[3];
      8'h0d: return `ACRM_IDENTITY_VAL;
      8'h10: return live[4];
      8'h16: return live[5];
      default: return (a < 8'h19) ? rw[a][7:0] : 8'h00;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // One host access with fresh live inputs, then model update and compare.
  task automatic access(input logic ld, input logic wr, input logic rd, input logic [7:0] d);
    logic [7:0] p;
    logic       pop_exp;
    int         k;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      smp[i] <= rng[13:0];
      live[i] <= rng[31:24];
    end
    p = reg_ptr;
    u_acrm_host_model.strobe(ld, wr, rd, d);
    if (rd) check(rd_data, expv(p));
    pop_exp = rd && !ld && rw[9][7:6] != 2'b00 && p == 8'h01;
    check({7'h00, fifo_pop}, {7'h00, pop_exp});
    if (wr && p < 8'h19 && RW_MASK[p[4:0]]) rw[p] = d;
    // Every writable register output against the model, in address order.
    k = 0;
    for (int j = 0; j < 25; j++) begin
      if (RW_MASK[j]) begin
        check(cfg[k], rw[j][7:0]);
        k++;
      end
    end
    p = ld ? d : nxt(p);
    check(reg_ptr, p);
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // -----
  // Tests
  // -----
  initial begin
    for (int i = 0; i < 25; i++) rw[i] = 0;
    rw[17] = 8'h80;
    rw[20] = 8'h1a;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 26; a++) begin
      access(1, 0, 0, a[7:0]);
      repeat (2) access(0, 0, 1, 8'h00);
    end
    $display("Test reset map done");
    for (int a = 0; a < 26; a++) begin
      if (a == 7 || a == 8) continue;
      rng = xs(rng);
      access(1, 0, 0, a[7:0]);
      access(0, 1, 0, rng[7:0]);
      access(1, 0, 0, a[7:0]);
      access(0, 0, 1, 8'h00);
    end
    $display("Test writes done");
    // Every buffer mode code with and without fast read.
    for (int m = 0; m < 8; m++) begin
      access(1, 0, 0, 8'h09);
      access(0, 1, 0, {m[2:1], 6'h05});
      @(posedge ref_clk);
      fast_read <= m[0];
      access(1, 0, 0, 8'h01);
      repeat (4) access(0, 0, 1, 8'h00);
      access(1, 0, 0, 8'h02);
      repeat (m[0] ? 1 : 3) access(0, 0, 1, 8'h00);
      check(cfg[0], rw[9][7:0]);
    end
    $display("Test modes done");
    conclude();
  end
  // Watchdog well beyond the roughly 800 cycles the tests need.
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
